// File: src/aqc_pkg.sv
// Shared constants and types of the acquisition clock qualifier.
package aqc_pkg;
    // ==========================================================
    // Geometry
    // ==========================================================
    localparam int NPROBE      = 8;
    localparam int NBLK        = 4;
    localparam int BLK_W       = 16;
    localparam int HALF_W      = 8;
    localparam int NCH         = 64;
    localparam int NEXT        = 4;
    localparam int NQW         = 6;
    localparam int QW          = 6;
    localparam int QPIN_LO     = 2;
    localparam int FIFO_DEPTH  = 16;
    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned RATE_BASE_NS  = 10;
    localparam int unsigned RATE_STEPS    = 24;
    localparam logic [4:0]  RATE_MIN_NI   = 5'h01;
    localparam logic [4:0]  RATE_MAX      = 5'h17;
    // ==========================================================
    // Edge selection, bit 0 rising and bit 1 falling
    // ==========================================================
    localparam logic [1:0] EDGE_OFF  = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam int         EDGE_BIT_RISE = 0;
    localparam int         EDGE_BIT_FALL = 1;
    // ==========================================================
    // Types
    // ==========================================================
    typedef struct packed {
        logic [QW-1:0] care;
        logic [QW-1:0] value;
        logic          minus;
    } aqc_qword_s;
    typedef struct packed {
        aqc_qword_s [NQW-1:0] word;
        logic [1:0]           edge_sel;
    } aqc_clkcfg_s;
    typedef struct packed {
        logic [NBLK-1:0] blk_valid;
        logic [NCH-1:0]  data;
    } aqc_sample_s;
    localparam int SAMPLE_W = $bits(aqc_sample_s);
endpackage

// File: src/aqc_top.sv
// Acquisition clock selection, qualification, glitch latching and sample buffer.
// Functional notes
// - Memory in 16-channel blocks; interlace halves channels, doubles rate and depth.
// - Interlace blocks use internal clock; concurrent non-interlace blocks use external clocks.
// - Combined non-interlace blocks sample on OR of member external clocks.
// - Each external clock: rising, falling, both edges, or disabled.
// - Internal clock is never ORed with any external clock.
// - Internal period in 1-2-5 steps: 20 ns (10 ns interlace) to 500 ms.
// - Six qualifier words per single edge; three word pairs for both edges.
// - Qualifier bit is 1, 0 or X; failed qualification stores no sample.
// - Bits within one qualifier word are ANDed at the same edge.
// - Words are ORed; trailing all-X words are ignored.
// - With both edges, plus words qualify rising, minus words falling.
// - Both clocks of a probe share qualifier pins 2 to 7, own words each.
// - Internal clock is never gated by qualifier inputs.
// - Glitch mode: odd channels hold glitch flags of paired even inputs.
// - Glitch mode only on non-interlace channels.
// - Glitch detector catches asynchronous glitches, also beside edges, externally clocked.
// - Trigger on glitch channels uses the master clock sampling them.
// - External clocks are pins 0 and 1 of clock probes J and K.
// - First master clock is the clock of probes 1 and 2.
`timescale 1ns/10ps
module aqc_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_data,
    input  wire logic         i_valid,
    output logic              o_ready,
    output logic [W-1:0]      o_data,
    output logic              o_valid,
    input  wire logic         i_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wptr_r;
    logic [AW:0]  rptr_r;
    wire          full  = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
    wire          empty = (wptr_r == rptr_r);
    wire          push  = i_ce && i_valid && !full;
    wire          pop   = i_ce && i_ready && !empty;
    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data  = mem[rptr_r[AW-1:0]];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wptr_r[AW-1:0]] <= i_data;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wptr_r <= '0;
            rptr_r <= '0;
        end else begin
            if (push) wptr_r <= wptr_r + 1'b1;
            if (pop) rptr_r <= rptr_r + 1'b1;
        end
    end
endmodule // aqc_fifo

module aqc_top #(
    parameter int unsigned P_RATE_DIV = 1
) (
    input  wire logic                 I_CLK,
    input  wire logic                 I_RST_N,
    input  wire logic                 I_CE,
    input  wire logic                 I_RUN,
    input  wire logic [63:0]          I_PROBE,
    input  wire logic [7:0]           I_CLK_PROBE_J,
    input  wire logic [7:0]           I_CLK_PROBE_K,
    input  wire logic [3:0]           I_INTERLACE,
    input  wire logic [3:0]           I_INT_SEL,
    input  wire logic [2:0]           I_MERGE,
    input  wire logic [7:0]           I_GLITCH,
    input  wire logic [4:0]           I_RATE_IDX,
    input  wire aqc_pkg::aqc_clkcfg_s I_CLK_CFG [4],
    output aqc_pkg::aqc_sample_s      O_SAMPLE,
    output logic                      O_SAMPLE_VALID,
    input  wire logic                 I_SAMPLE_READY,
    output logic                      O_FIRST_MASTER_CLOCK,
    output logic                      O_OVERRUN
);
    localparam int SW = aqc_pkg::NCH + 16;

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic [SW-1:0] meta_r;
    logic [SW-1:0] sync_r;
    logic [SW-1:0] prev_r;
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else if (I_CE) begin
            meta_r <= {I_CLK_PROBE_K, I_CLK_PROBE_J, I_PROBE};
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end
    wire [63:0] probe   = sync_r[63:0];
    wire [63:0] probe_p = prev_r[63:0];
    wire [7:0]  cpj     = sync_r[71:64];
    wire [7:0]  cpk     = sync_r[79:72];
    wire [7:0]  cpj_p   = prev_r[71:64];
    wire [7:0]  cpk_p   = prev_r[79:72];

    // ==========================================================
    // Configuration, captured while stopped
    // ==========================================================
    logic [3:0]           il_r;
    logic [3:0]           isel_r;
    logic [2:0]           merge_r;
    logic [7:0]           gl_r;
    logic [4:0]           rate_r;
    aqc_pkg::aqc_clkcfg_s ccfg_r [4];
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            il_r    <= '0;
            isel_r  <= '0;
            merge_r <= '0;
            gl_r    <= '0;
            rate_r  <= '0;
            ccfg_r  <= '{default: '0};
        end else if (I_CE && !I_RUN) begin
            il_r    <= I_INTERLACE;
            isel_r  <= I_INT_SEL;
            merge_r <= I_MERGE;
            gl_r    <= I_GLITCH;
            rate_r  <= I_RATE_IDX;
            ccfg_r  <= I_CLK_CFG;
        end
    end

    // ==========================================================
    // Internal sample clock
    // ==========================================================
    function automatic logic [31:0] rate_cycles(input logic [4:0] idx);
        int unsigned ns;
        int unsigned cyc;
        ns = aqc_pkg::RATE_BASE_NS;
        for (int d = 0; d < 8; d++) begin
            if (int'(idx) / 3 > d) ns = ns * 10;
        end
        if (int'(idx) % 3 == 1) ns = ns * 2;
        if (int'(idx) % 3 == 2) ns = ns * 5;
        cyc = ns / aqc_pkg::CLK_PERIOD_NS / P_RATE_DIV;
        if (cyc == 0) cyc = 1;
        return 32'(cyc);
    endfunction
    // Only interlace may reach the fastest step.
    wire [4:0] rate_lo  = (|il_r) ? 5'h00 : aqc_pkg::RATE_MIN_NI;
    wire [4:0] rate_hi  = (rate_r > aqc_pkg::RATE_MAX) ? aqc_pkg::RATE_MAX : rate_r;
    wire [4:0] rate_eff = (rate_hi < rate_lo) ? rate_lo : rate_hi;
    wire [31:0] rate_lim = rate_cycles(rate_eff) - 32'h0000_0001;
    logic [31:0] icnt_r;
    wire         int_tick = I_RUN && (icnt_r == 32'h0000_0000);
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) icnt_r <= '0;
        else if (I_CE) icnt_r <= (!I_RUN || int_tick) ? rate_lim : icnt_r - 32'h0000_0001;
    end

    // ==========================================================
    // External clocks and qualifiers
    // ==========================================================
    function automatic logic qual_ok(input aqc_pkg::aqc_clkcfg_s cfg,
                                     input logic [5:0] q, input logic fall);
        logic later;
        logic any_v;
        logic hit;
        logic both;
        logic live;
        later = 1'b0;
        any_v = 1'b0;
        hit   = 1'b0;
        both  = (cfg.edge_sel == aqc_pkg::EDGE_BOTH);
        for (int w = aqc_pkg::NQW - 1; w >= 0; w--) begin
            live  = (|cfg.word[w].care) || later;
            later = live;
            if (live && (!both || (cfg.word[w].minus == fall))) begin
                any_v = 1'b1;
                if ((~(q ^ cfg.word[w].value) & cfg.word[w].care) == cfg.word[w].care) begin
                    hit = 1'b1;
                end
            end
        end
        return hit || !any_v;
    endfunction

    wire clock_probe_j_pin0 = cpj[0];
    wire clock_probe_j_pin1 = cpj[1];
    wire clock_probe_k_pin0 = cpk[0];
    wire clock_probe_k_pin1 = cpk[1];
    wire [3:0] ext_now  = {clock_probe_k_pin1, clock_probe_k_pin0,
                           clock_probe_j_pin1, clock_probe_j_pin0};
    wire [3:0] ext_past = {cpk_p[1], cpk_p[0], cpj_p[1], cpj_p[0]};
    logic [3:0] ext_ev;
    for (genvar c = 0; c < aqc_pkg::NEXT; c++) begin : g_ext
        // Shared qualifier pins; synchronised alongside the clock so they line up.
        wire [5:0] q = (c < 2) ? cpj[7:aqc_pkg::QPIN_LO] : cpk[7:aqc_pkg::QPIN_LO];
        wire rise = ext_now[c] && !ext_past[c];
        wire fall = !ext_now[c] && ext_past[c];
        assign ext_ev[c] = I_RUN && (
            (rise && ccfg_r[c].edge_sel[aqc_pkg::EDGE_BIT_RISE] && qual_ok(ccfg_r[c], q, 1'b0)) ||
            (fall && ccfg_r[c].edge_sel[aqc_pkg::EDGE_BIT_FALL] && qual_ok(ccfg_r[c], q, 1'b1)));
    end

    // ==========================================================
    // Block clock selection and grouping
    // ==========================================================
    wire [3:0] use_int = il_r | (isel_r & {4{~|il_r}});
    wire [2:0] mrg     = merge_r & ~il_r[2:0] & ~il_r[3:1];
    logic [1:0] lead [4];
    logic [3:0] blk_ev;
    always_comb begin
        lead[0] = 2'h0;
        for (int b = 1; b < aqc_pkg::NBLK; b++) begin
            lead[b] = mrg[b-1] ? lead[b-1] : 2'(b);
        end
        for (int b = 0; b < aqc_pkg::NBLK; b++) begin
            blk_ev[b] = 1'b0;
            for (int c = 0; c < aqc_pkg::NBLK; c++) begin
                if (lead[c] == lead[b]) blk_ev[b] = blk_ev[b] | ext_ev[c];
            end
            // A group follows its lead; internal and external are never mixed.
            if (use_int[lead[b]]) blk_ev[b] = int_tick;
        end
    end

    // ==========================================================
    // Glitch latching and sample assembly
    // ==========================================================
    wire        fifo_rdy;
    logic [1:0] tog_r [32];
    logic [7:0] lo_r  [4];
    logic [3:0] half_r;
    logic [3:0] emit;
    logic [63:0] word;
    logic [31:0] glitch;
    wire  [7:0] gl_eff;
    for (genvar p = 0; p < aqc_pkg::NPROBE; p++) begin : g_gl
        assign gl_eff[p] = gl_r[p] && !il_r[p/2] && !use_int[lead[p/2]];
    end
    for (genvar e = 0; e < 32; e++) begin : g_tog
        wire tr = probe[2*e] ^ probe_p[2*e];
        // Two or more transitions between samples are a glitch, even beside an edge.
        assign glitch[e] = (tog_r[e] + {1'b0, tr}) >= 2'h2;
        always_ff @(posedge I_CLK or negedge I_RST_N) begin
            if (!I_RST_N) tog_r[e] <= '0;
            else if (I_CE) begin
                if (blk_ev[e/8] && fifo_rdy) tog_r[e] <= {1'b0, tr};
                else if (tr && tog_r[e] != 2'h2) tog_r[e] <= tog_r[e] + 2'h1;
            end
        end
    end
    always_comb begin
        for (int b = 0; b < aqc_pkg::NBLK; b++) begin
            word[b*16 +: 16] = probe[b*16 +: 16];
            for (int k = 0; k < 16; k += 2) begin
                if (gl_eff[(b*16+k)/8]) word[b*16+k+1] = glitch[(b*16+k)/2];
            end
            if (il_r[b]) word[b*16 +: 16] = {probe[b*16 +: 8], lo_r[b]};
            emit[b] = blk_ev[b] && (!il_r[b] || half_r[b]);
        end
    end
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            half_r <= '0;
            lo_r   <= '{default: '0};
        end else if (I_CE) begin
            for (int b = 0; b < aqc_pkg::NBLK; b++) begin
                if (!I_RUN) half_r[b] <= 1'b0;
                else if (blk_ev[b] && il_r[b] && fifo_rdy) begin
                    half_r[b] <= !half_r[b];
                    if (!half_r[b]) lo_r[b] <= probe[b*16 +: 8];
                end
            end
        end
    end

    // ==========================================================
    // Master clock, overrun and buffer
    // ==========================================================
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_FIRST_MASTER_CLOCK <= 1'b0;
            O_OVERRUN            <= 1'b0;
        end else if (I_CE) begin
            O_FIRST_MASTER_CLOCK <= blk_ev[0];
            if (!I_RUN) O_OVERRUN <= 1'b0;
            else if ((|emit) && !fifo_rdy) O_OVERRUN <= 1'b1;
        end
    end
    aqc_fifo #(.W(aqc_pkg::SAMPLE_W), .DEPTH(aqc_pkg::FIFO_DEPTH)) u_fifo (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_ce    (I_CE),
        .i_data  ({emit, word}),
        .i_valid (|emit),
        .o_ready (fifo_rdy),
        .o_data  (O_SAMPLE),
        .o_valid (O_SAMPLE_VALID),
        .i_ready (I_SAMPLE_READY)
    );
endmodule // aqc_top

// File: testbench/aqc_sut_model.sv
// Behavioural system under test driving the data probes and clock probe J.
`timescale 1ns/10ps
module aqc_sut_model (
    input  wire logic       i_start,
    input  wire logic       i_glitch,
    input  wire logic [5:0] i_qual,
    input  wire logic [7:0] i_npulse,
    output logic [7:0]      o_clk_probe,
    output logic [63:0]     o_probe,
    output logic            o_busy
);
    // ==========================================================
    // Frames of the 80 ns link clock
    // ==========================================================
    logic       clk0 = 1'b0;
    logic       gl   = 1'b0;
    logic [7:0] cnt  = 8'h00;
    initial o_busy = 1'b0;
    // Pin 1 stays still, so a merged group can only see the edges of pin 0.
    assign o_clk_probe = {i_qual, 1'b0, clk0};
    assign o_probe     = {8{cnt[7:1], cnt[0] ^ gl}};
    // Data moves late in the low phase so that both edges see settled data.
    always @(posedge i_start) begin
        o_busy = 1'b1;
        for (int i = 0; i < i_npulse; i++) begin
            clk0 = 1'b1;
            #40 clk0 = 1'b0;
            #4 gl = i_glitch;
            #16 gl = 1'b0;
            #8 cnt = cnt + 8'h01;
            #12;
        end
        cnt = 8'h00;
        o_busy = 1'b0;
    end
endmodule // aqc_sut_model

// File: testbench/aqc_top_monitor.sv
// Port-level concurrent checks of the acquisition clock qualifier.
`timescale 1ns/10ps
module aqc_mon #(
    parameter int unsigned P_RATE_DIV = 1
) (
    input wire logic                 I_CLK,
    input wire logic                 I_RST_N,
    input wire logic                 I_CE,
    input wire logic                 I_RUN,
    input wire logic [3:0]           I_INTERLACE,
    input wire logic [7:0]           I_CLK_PROBE_J,
    input wire logic [3:0]           I_INT_SEL,
    input wire aqc_pkg::aqc_clkcfg_s I_CLK_CFG [4],
    input wire aqc_pkg::aqc_sample_s O_SAMPLE,
    input wire logic                 O_SAMPLE_VALID,
    input wire logic                 I_SAMPLE_READY,
    input wire logic                 O_FIRST_MASTER_CLOCK,
    input wire logic                 O_OVERRUN
);
    // ==========================================================
    // Sequences
    // ==========================================================
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);
    sequence s_stopped;
        I_CE && !I_RUN ##1 I_CE && !I_RUN;
    endsequence
    // Only the plain case is timed: no words, rising edge, external lead, sink ready.
    sequence s_rise_j0;
        $rose(I_CLK_PROBE_J[0]) && I_RUN && I_SAMPLE_READY && I_INT_SEL == 4'h0
            && I_CLK_CFG[0].edge_sel == aqc_pkg::EDGE_RISE && I_CLK_CFG[0].word == '0;
    endsequence
    // ==========================================================
    // Assertions
    // ==========================================================
    a_edge_to_pulse: assert property (s_rise_j0 |-> ##3 O_FIRST_MASTER_CLOCK)
        else $error("Edge gave no master clock pulse");
    a_stop_quiet: assert property (s_stopped |=> !O_FIRST_MASTER_CLOCK)
        else $error("Sample taken while stopped");
    a_overrun_clear: assert property (s_stopped |-> !O_OVERRUN)
        else $error("Overrun kept while stopped");
    a_overrun_sticky: assert property (O_OVERRUN && I_RUN |=> O_OVERRUN)
        else $error("Overrun dropped in run");
    a_overrun_cause: assert property ($rose(O_OVERRUN) |-> $past(O_SAMPLE_VALID && I_RUN))
        else $error("Overrun without stored samples");
    a_head_held: assert property (O_SAMPLE_VALID && !I_SAMPLE_READY
        |=> O_SAMPLE_VALID && $stable(O_SAMPLE))
        else $error("Head changed without pop");
    a_pop_only: assert property ($fell(O_SAMPLE_VALID) |-> $past(I_SAMPLE_READY))
        else $error("Buffer emptied without pop");
    // An interlaced block only parks the low half on the first tick of each pair, so nothing is stored then.
    a_master_valid: assert property (O_FIRST_MASTER_CLOCK && !I_INTERLACE[0]
        |-> O_SAMPLE_VALID || O_OVERRUN)
        else $error("Master clock pulse without sample");
    a_ce_freeze: assert property (!I_CE |=> $stable(O_SAMPLE_VALID) && $stable(O_OVERRUN))
        else $error("State moved with enable low");
endmodule // aqc_mon
bind aqc_top aqc_mon #(.P_RATE_DIV(P_RATE_DIV)) i_aqc_mon (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
    .I_CE(I_CE), .I_RUN(I_RUN), .I_INTERLACE(I_INTERLACE), .I_CLK_PROBE_J(I_CLK_PROBE_J),
    .I_INT_SEL(I_INT_SEL), .I_CLK_CFG(I_CLK_CFG), .O_SAMPLE(O_SAMPLE),
    .O_SAMPLE_VALID(O_SAMPLE_VALID),
    .I_SAMPLE_READY(I_SAMPLE_READY), .O_FIRST_MASTER_CLOCK(O_FIRST_MASTER_CLOCK),
    .O_OVERRUN(O_OVERRUN));

// File: testbench/tb.sv
// Self-checking bench of the acquisition clock qualifier.
`timescale 1ns/10ps
module tb;
    // ==========================================================
    // Signals
    // ==========================================================
    logic                 clk = 1'b0, rst_n = 1'b0, ce = 1'b1, run = 1'b0, rdy = 1'b1;
    logic                 go = 1'b0, glt = 1'b0, sv, fmc, ovr, busy, ovr_seen;
    logic [5:0]           qual = 6'h00;
    logic [7:0]           npul = 8'h04, gmode = 8'h00, jpin;
    logic [3:0]           ilace = 4'h0, isel = 4'h0;
    logic [2:0]           merge = 3'h0;
    logic [4:0]           ridx = 5'h01;
    logic [63:0]          probe;
    aqc_pkg::aqc_clkcfg_s cfg [4];
    aqc_pkg::aqc_sample_s smp;
    aqc_pkg::aqc_sample_s got [$];
    int                   bad_count = 0, checks_done = 0, fmc_n = 0;
    aqc_sut_model i_aqc_sut_model (.i_start(go), .i_glitch(glt), .i_qual(qual), .i_npulse(npul),
        .o_clk_probe(jpin), .o_probe(probe), .o_busy(busy));
    // Clock probe K sees a copy of the J frame, so the K clock pins are exercised too.
    aqc_top i_aqc_top (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_RUN(run), .I_PROBE(probe),
        .I_CLK_PROBE_J(jpin), .I_CLK_PROBE_K(jpin), .I_INTERLACE(ilace), .I_INT_SEL(isel),
        .I_MERGE(merge), .I_GLITCH(gmode), .I_RATE_IDX(ridx), .I_CLK_CFG(cfg), .O_SAMPLE(smp),
        .O_SAMPLE_VALID(sv), .I_SAMPLE_READY(rdy), .O_FIRST_MASTER_CLOCK(fmc), .O_OVERRUN(ovr));
    always #4 clk = ~clk;
    // Outputs are read half a cycle after the edge that launches them, once they have settled.
    always @(negedge clk) begin
        if (sv && rdy && ce) got.push_back(smp);
        if (fmc) fmc_n++;
        if (ovr) ovr_seen = 1'b1;
    end
    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Config is only taken while stopped, so changes land before the run starts and the lock change waits for the stop.
    task automatic burst(input logic [7:0] n, input logic lock);
        got.delete();
        fmc_n = 0;
        ovr_seen = 1'b0;
        repeat (2) @(posedge clk);
        #1 run = 1'b1;
        npul = n;
        go = 1'b1;
        @(posedge clk);
        #1 go = 1'b0;
        if (lock) cfg[0].edge_sel = aqc_pkg::EDGE_OFF;
        // A frame that never ends is left to the watchdog, which counts it as a mismatch.
        while (busy) @(posedge clk);
        repeat (8) @(posedge clk);
        #1 rdy = 1'b1;
        run = 1'b0;
        repeat (24) @(posedge clk);
        #1;
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_edges;
        for (int e = 0; e < 4; e++) begin
            cfg[0].edge_sel = 2'(e);
            burst(8'h04, 1'b0);
            chk(64'(got.size()), (e == 0) ? 64'h0 : (e == 3) ? 64'h8 : 64'h4);
            chk(64'(fmc_n), 64'(got.size()));
            foreach (got[i]) begin
                chk(64'(got[i].blk_valid), 64'h1);
                chk(64'(got[i].data[7:0]), 64'((e == 3) ? i / 2 : i));
            end
        end
    endtask
    task automatic t_qual;
        logic [5:0] tv [5][4] = '{'{6'h3F, 6'h15, 6'h00, 6'h15}, '{6'h3F, 6'h15, 6'h00, 6'h14},
            '{6'h3F, 6'h00, 6'h00, 6'h15}, '{6'h3F, 6'h00, 6'h01, 6'h15},
            '{6'h2A, 6'h00, 6'h00, 6'h15}};
        logic [2:0] tx [5] = '{3'h4, 3'h0, 3'h0, 3'h4, 3'h4};
        cfg[0].edge_sel = aqc_pkg::EDGE_RISE;
        for (int r = 0; r < 5; r++) begin
            cfg[0].word[0].care = tv[r][0];
            cfg[0].word[0].value = tv[r][1];
            cfg[0].word[2].care = tv[r][2];
            qual = tv[r][3];
            burst(8'h04, 1'b0);
            chk(64'(got.size()), 64'(tx[r]));
        end
        cfg[0].word = '0;
    endtask
    task automatic t_both;
        cfg[0].edge_sel = aqc_pkg::EDGE_BOTH;
        qual = 6'h2D;
        for (int s = 0; s < 2; s++) begin
            cfg[0].word[0] = '{care: 6'h3F, value: (s == 0) ? 6'h2D : 6'h12, minus: 1'b0};
            cfg[0].word[1] = '{care: 6'h3F, value: (s == 0) ? 6'h12 : 6'h2D, minus: 1'b1};
            burst(8'h04, 1'b0);
            chk(64'(got.size()), 64'h4);
        end
        cfg[0].word = '0;
    endtask
    task automatic t_merge_glitch;
        // Only K pin 0 clocks the three merged blocks, so block 0 samples through the OR alone.
        merge = 3'h3;
        gmode = 8'h01;
        glt = 1'b1;
        cfg[0].edge_sel = aqc_pkg::EDGE_OFF;
        cfg[2].edge_sel = aqc_pkg::EDGE_RISE;
        burst(8'h04, 1'b0);
        chk(64'(got.size()), 64'h4);
        foreach (got[i]) begin
            chk(64'(got[i].blk_valid), 64'h7);
            chk(64'({got[i].data[9], got[i].data[1]}), 64'({i[1], i != 0}));
        end
        merge = 3'h0;
        gmode = 8'h00;
        glt = 1'b0;
        cfg[0].edge_sel = aqc_pkg::EDGE_RISE;
        cfg[2] = '0;
    endtask
    // External edges keep coming during the internal runs; none may add a sample.
    task automatic t_internal;
        int rows [3][3] = '{'{0, 0, 0}, '{1, 0, 0}, '{0, 1, 63}};
        isel = 4'h1;
        qual = 6'h15;
        for (int r = 0; r < 3; r++) begin
            ilace = 4'(rows[r][0]);
            ridx = 5'(rows[r][1]);
            cfg[0].word[0].care = 6'(rows[r][2]);
            got.delete();
            repeat (2) @(posedge clk);
            #1 run = 1'b1;
            go = 1'b1;
            repeat (40) @(posedge clk);
            #1 run = 1'b0;
            go = 1'b0;
            while (busy) @(posedge clk);
            repeat (4) @(posedge clk);
            #1 chk(64'(got.size()), 64'h14);
        end
        isel = 4'h0;
        ilace = 4'h0;
        cfg[0].word = '0;
    endtask
    task automatic t_lock_overrun;
        burst(8'h04, 1'b1);
        chk(64'(got.size()), 64'h4);
        cfg[0].edge_sel = aqc_pkg::EDGE_RISE;
        rdy = 1'b0;
        burst(8'h14, 1'b0);
        chk(64'({ovr_seen, ovr}), 64'h2);
        chk(64'(got.size()), 64'h10);
        chk(64'(got[15].data[7:0]), 64'h0F);
    endtask
    // A stored sample must wait out a low enable even though the sink is ready.
    task automatic t_freeze;
        got.delete();
        rdy = 1'b0;
        npul = 8'h01;
        run = 1'b1;
        go = 1'b1;
        repeat (12) @(posedge clk);
        #1 go = 1'b0;
        ce = 1'b0;
        rdy = 1'b1;
        repeat (4) @(posedge clk);
        #1 chk(64'({sv, got.size() == 0}), 64'h3);
        ce = 1'b1;
        run = 1'b0;
        repeat (4) @(posedge clk);
        #1 chk(64'(got.size()), 64'h1);
    endtask
    task automatic end_sim;
        $display("Checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        foreach (cfg[i]) cfg[i] = '0;
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        chk(64'({sv, fmc, ovr}), 64'h0);
        ce = 1'b0;
        repeat (3) @(posedge clk);
        #1 ce = 1'b1;
        t_edges();
        t_qual();
        t_both();
        t_merge_glitch();
        t_internal();
        t_lock_overrun();
        t_freeze();
        end_sim();
    end
    initial begin
        #100_000;
        bad_count++;
        end_sim();
    end
endmodule // tb
